// [core/mdp_error_inject_capture.v]
// Memory data path error injection masks and error capture monitors.
// Assumes the ECC/parity checkers supply one-cycle error pulses with the failing word,
// and that the local bus and PCI register ports are synchronous to clk_i.
// Read data, hit flags and the masked paths are combinational; all state is clocked.
`include "mdp_diag_defs.vh"
`default_nettype none

// Notes on behaviour
// RQ1: Every set mask bit inverts its bus bit and clear bits pass the bus unchanged.
// RQ2: There are separate masks for the upper data half, lower data half and parity lanes.
// RQ3: With the read enable bit set, masks alter read data toward the peripheral bus.
// RQ4: With the write enable bit set, masks alter write data toward external memory.
// RQ5: The parity mask sits in bits 7 to 0 of the injection parity register.
// RQ6: The three mask registers are read/write and clear to zero at reset.
// RQ7: Capture loads on read threshold, multi-bit ECC or write parity error.
// RQ8: Loading the monitors sets the capture flag in bit 8 of the capture parity register.
// RQ9: The flag stays set until software writes it to zero.
// RQ10: While the flag is set no monitor changes.
// RQ11: Apart from the flag, the capture monitors ignore software writes.
// RQ12: Capture is split into upper, lower and parity monitors, parity in bits 7 to 0.
// RQ13: The word captured is from whichever path, read or write, carried the error.
// RQ14: Local bus accesses decode in the window 0xFF000 to 0xFFFFF.
// RQ15: PCI accesses decode in the window 0xF00 to 0xFFF with the same layout.
// RQ16: Reserved bits of the two parity registers read as zero and ignore writes.
module mdp_error_inject_capture #(
  parameter DATA_W = 32,
  parameter PAR_W  = 8
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              reset_n_i,
  // Local bus register port.
  input  wire              lb_sel_i,
  input  wire              lb_wr_i,
  input  wire [19:0]       lb_offset_i,
  input  wire [3:0]        lb_be_i,
  input  wire [31:0]       lb_wdata_i,
  output wire [31:0]       lb_rdata_o,
  output wire              lb_hit_o,
  // PCI register port.
  input  wire              pci_sel_i,
  input  wire              pci_wr_i,
  input  wire [11:0]       pci_offset_i,
  input  wire [3:0]        pci_be_i,
  input  wire [31:0]       pci_wdata_i,
  output wire [31:0]       pci_rdata_o,
  output wire              pci_hit_o,
  // Read path from memory toward the peripheral logic bus.
  input  wire [DATA_W-1:0] rd_upper_word_bits_i,
  input  wire [DATA_W-1:0] rd_lower_word_bits_i,
  input  wire [PAR_W-1:0]  rd_parity_lane_bits_i,
  output wire [DATA_W-1:0] rd_upper_word_bits_o,
  output wire [DATA_W-1:0] rd_lower_word_bits_o,
  output wire [PAR_W-1:0]  rd_parity_lane_bits_o,
  // Write path toward external memory.
  input  wire [DATA_W-1:0] wr_upper_word_bits_i,
  input  wire [DATA_W-1:0] wr_lower_word_bits_i,
  input  wire [PAR_W-1:0]  wr_parity_lane_bits_i,
  output wire [DATA_W-1:0] wr_upper_word_bits_o,
  output wire [DATA_W-1:0] wr_lower_word_bits_o,
  output wire [PAR_W-1:0]  wr_parity_lane_bits_o,
  // Error events from the detection registers.
  input  wire              err_rd_threshold_i,
  input  wire              err_multi_bit_i,
  input  wire              err_wr_parity_i,
  // Capture flag state.
  output wire              capture_valid_o
);

  reg  [DATA_W-1:0] inj_high_reg;
  reg  [DATA_W-1:0] inj_low_reg;
  reg  [PAR_W-1:0]  inj_par_reg;
  reg               inj_wr_en_reg;
  reg               inj_rd_en_reg;
  reg  [DATA_W-1:0] cap_high_reg;
  reg  [DATA_W-1:0] cap_low_reg;
  reg  [PAR_W-1:0]  cap_par_reg;
  reg               cap_flag_reg;

  wire [5:0]  lb_dec;
  wire [5:0]  pci_dec;
  wire [5:0]  lb_reg_sel;
  wire [5:0]  pci_reg_sel;
  wire        lb_in_win;
  wire        pci_in_win;
  wire        use_pci;
  wire        wr_act;
  wire [5:0]  wr_sel;
  wire [3:0]  wr_be;
  wire [31:0] wr_data;
  wire [31:0] wr_merge_inj_par;
  wire [31:0] wr_merge_cap_par;
  wire        rd_err;
  wire        any_err;
  wire        flag_clear;
  wire        cap_load;
  wire        wr_inj_high;
  wire        wr_inj_low;
  wire        wr_inj_par;
  wire        wr_cap_par;
  wire [31:0] inj_par_word;
  wire [31:0] cap_par_word;

  wire [DATA_W-1:0] rd_mask_high;
  wire [DATA_W-1:0] rd_mask_low;
  wire [PAR_W-1:0]  rd_mask_par;
  wire [DATA_W-1:0] wr_mask_high;
  wire [DATA_W-1:0] wr_mask_low;
  wire [PAR_W-1:0]  wr_mask_par;

  reg  [DATA_W-1:0] inj_high_next;
  reg  [DATA_W-1:0] inj_low_next;
  reg  [PAR_W-1:0]  inj_par_next;
  reg               inj_wr_en_next;
  reg               inj_rd_en_next;
  reg  [DATA_W-1:0] cap_high_next;
  reg  [DATA_W-1:0] cap_low_next;
  reg  [PAR_W-1:0]  cap_par_next;
  reg               cap_flag_next;
  reg  [31:0]       lb_rdata_mux;
  reg  [31:0]       pci_rdata_mux;

  mdp_reg_decode u_lb_dec (
    .lb_offset_i  (lb_offset_i),
    .pci_offset_i (12'h000),
    .use_pci_i    (1'b0),
    .sel_o        (lb_dec)
  );

  mdp_reg_decode u_pci_dec (
    .lb_offset_i  (20'h00000),
    .pci_offset_i (pci_offset_i),
    .use_pci_i    (1'b1),
    .sel_o        (pci_dec)
  );

  // Each window ends at the top of its offset range, so only the lower bound can miss.
  assign lb_in_win   = (lb_offset_i >= `LB_WIN_LO) && (lb_offset_i <= `LB_WIN_HI);   // [RQ14]
  assign pci_in_win  = (pci_offset_i >= `PCI_WIN_LO) && (pci_offset_i <= `PCI_WIN_HI); // [RQ15]
  assign lb_reg_sel  = (lb_sel_i && lb_in_win) ? lb_dec : `SEL_NONE;
  assign pci_reg_sel = (pci_sel_i && pci_in_win) ? pci_dec : `SEL_NONE;
  assign lb_hit_o    = lb_sel_i && lb_in_win;
  assign pci_hit_o   = pci_sel_i && pci_in_win;

  // The local bus wins when both ports write in the same cycle.
  assign use_pci = !(lb_sel_i && lb_wr_i);
  assign wr_act  = (lb_sel_i && lb_wr_i) || (pci_sel_i && pci_wr_i);
  assign wr_sel  = use_pci ? pci_reg_sel : lb_reg_sel;
  assign wr_be   = use_pci ? pci_be_i : lb_be_i;
  assign wr_data = use_pci ? pci_wdata_i : lb_wdata_i;

  // One strobe per writable register, from whichever port owns the write.
  assign wr_inj_high = wr_act && (wr_sel == `SEL_INJ_HIGH);
  assign wr_inj_low  = wr_act && (wr_sel == `SEL_INJ_LOW);
  assign wr_inj_par  = wr_act && (wr_sel == `SEL_INJ_PAR);
  assign wr_cap_par  = wr_act && (wr_sel == `SEL_CAP_PAR);

  // Byte-lane merge for the two registers that accept partial writes.
  assign wr_merge_inj_par = {
    16'h0000,
    wr_be[1] ? wr_data[15:8] : {6'h00, inj_rd_en_reg, inj_wr_en_reg},
    wr_be[0] ? wr_data[7:0]  : inj_par_reg
  };
  assign wr_merge_cap_par = {
    16'h0000,
    wr_be[1] ? wr_data[15:8] : {7'h00, cap_flag_reg},
    8'h00
  };

  // Next values of the mask registers; a write changes only the register it selects.
  always @* begin
    inj_high_next  = inj_high_reg;
    inj_low_next   = inj_low_reg;
    inj_par_next   = inj_par_reg;
    inj_wr_en_next = inj_wr_en_reg;
    inj_rd_en_next = inj_rd_en_reg;
    if (wr_inj_high) begin
      inj_high_next = wr_data[DATA_W-1:0]; // [RQ2]
    end
    if (wr_inj_low) begin
      inj_low_next = wr_data[DATA_W-1:0];
    end
    if (wr_inj_par) begin
      inj_par_next   = wr_merge_inj_par[`PAR_MSB:`PAR_LSB]; // [RQ5]
      inj_wr_en_next = wr_merge_inj_par[`INJ_WR_EN_BIT];
      inj_rd_en_next = wr_merge_inj_par[`INJ_RD_EN_BIT]; // [RQ16]
    end
  end

  // Injection masks and enables.
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inj_high_reg  <= `RST_WORD; // [RQ6]
      inj_low_reg   <= `RST_WORD;
      inj_par_reg   <= `RST_PAR;
      inj_wr_en_reg <= 1'b0;
      inj_rd_en_reg <= 1'b0;
    end else begin
      inj_high_reg  <= inj_high_next;
      inj_low_reg   <= inj_low_next;
      inj_par_reg   <= inj_par_next;
      inj_wr_en_reg <= inj_wr_en_next;
      inj_rd_en_reg <= inj_rd_en_next;
    end
  end

  // Each mask reaches only the path whose enable bit is set.
  assign rd_mask_high = inj_rd_en_reg ? inj_high_reg : {DATA_W{1'b0}}; // [RQ3]
  assign rd_mask_low  = inj_rd_en_reg ? inj_low_reg : {DATA_W{1'b0}};
  assign rd_mask_par  = inj_rd_en_reg ? inj_par_reg : {PAR_W{1'b0}};
  assign wr_mask_high = inj_wr_en_reg ? inj_high_reg : {DATA_W{1'b0}}; // [RQ4]
  assign wr_mask_low  = inj_wr_en_reg ? inj_low_reg : {DATA_W{1'b0}};
  assign wr_mask_par  = inj_wr_en_reg ? inj_par_reg : {PAR_W{1'b0}};

  // Bitwise inversion on each path; a clear mask bit passes its bus bit through.
  assign rd_upper_word_bits_o  = rd_upper_word_bits_i ^ rd_mask_high; // [RQ1]
  assign rd_lower_word_bits_o  = rd_lower_word_bits_i ^ rd_mask_low;
  assign rd_parity_lane_bits_o = rd_parity_lane_bits_i ^ rd_mask_par;
  assign wr_upper_word_bits_o  = wr_upper_word_bits_i ^ wr_mask_high; // [RQ1]
  assign wr_lower_word_bits_o  = wr_lower_word_bits_i ^ wr_mask_low;
  assign wr_parity_lane_bits_o = wr_parity_lane_bits_i ^ wr_mask_par;

  // Capture monitors.
  assign rd_err     = err_rd_threshold_i || err_multi_bit_i;
  assign any_err    = rd_err || err_wr_parity_i; // [RQ7]
  assign cap_load   = any_err && !cap_flag_reg; // [RQ10]
  assign flag_clear = wr_cap_par && !wr_merge_cap_par[`CAP_FLAG_BIT];

  // A read error captures the word as seen on the peripheral side and a write
  // error the word as driven to memory; a read error wins when both arrive.
  // With the flag set, an error arriving together with the clear is not captured.
  always @* begin
    if (rd_err) begin // [RQ13]
      cap_high_next = rd_upper_word_bits_o;
      cap_low_next  = rd_lower_word_bits_o;
      cap_par_next  = rd_parity_lane_bits_o;
    end else begin
      cap_high_next = wr_upper_word_bits_o;
      cap_low_next  = wr_lower_word_bits_o;
      cap_par_next  = wr_parity_lane_bits_o;
    end
    cap_flag_next = cap_flag_reg;
    if (cap_load) begin
      cap_flag_next = 1'b1; // [RQ8]
    end else if (flag_clear) begin
      cap_flag_next = 1'b0; // [RQ9] [RQ11]
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_high_reg <= `RST_WORD;
      cap_low_reg  <= `RST_WORD;
      cap_par_reg  <= `RST_PAR;
      cap_flag_reg <= 1'b0;
    end else begin
      if (cap_load) begin
        cap_high_reg <= cap_high_next; // [RQ12]
        cap_low_reg  <= cap_low_next;
        cap_par_reg  <= cap_par_next;
      end
      cap_flag_reg <= cap_flag_next;
    end
  end

  assign capture_valid_o = cap_flag_reg;

  // Read multiplexers; unmapped offsets and reserved bits read zero.
  assign inj_par_word = {22'h0, inj_rd_en_reg, inj_wr_en_reg, inj_par_reg};
  assign cap_par_word = {23'h0, cap_flag_reg, cap_par_reg}; // [RQ16]

  always @* begin
    case (lb_reg_sel)
      `SEL_INJ_HIGH: lb_rdata_mux = inj_high_reg;
      `SEL_INJ_LOW:  lb_rdata_mux = inj_low_reg;
      `SEL_INJ_PAR:  lb_rdata_mux = inj_par_word;
      `SEL_CAP_HIGH: lb_rdata_mux = cap_high_reg;
      `SEL_CAP_LOW:  lb_rdata_mux = cap_low_reg;
      `SEL_CAP_PAR:  lb_rdata_mux = cap_par_word;
      default:       lb_rdata_mux = `RST_WORD;
    endcase
  end

  always @* begin
    case (pci_reg_sel)
      `SEL_INJ_HIGH: pci_rdata_mux = inj_high_reg;
      `SEL_INJ_LOW:  pci_rdata_mux = inj_low_reg;
      `SEL_INJ_PAR:  pci_rdata_mux = inj_par_word;
      `SEL_CAP_HIGH: pci_rdata_mux = cap_high_reg;
      `SEL_CAP_LOW:  pci_rdata_mux = cap_low_reg;
      `SEL_CAP_PAR:  pci_rdata_mux = cap_par_word;
      default:       pci_rdata_mux = `RST_WORD;
    endcase
  end

  assign lb_rdata_o  = lb_rdata_mux;
  assign pci_rdata_o = pci_rdata_mux;

endmodule
`default_nettype wire

// [core/mdp_reg_decode.v]
// Register decoder for the diagnostic block: maps a byte offset to a one-hot selector.
// Assumes offsets relative to the utilities block base or the PCI register base.
`include "mdp_diag_defs.vh"
`default_nettype none

module mdp_reg_decode (
  // Access offsets.
  input  wire [19:0] lb_offset_i,
  input  wire [11:0] pci_offset_i,
  input  wire        use_pci_i,
  // Decoded selector.
  output reg  [5:0]  sel_o
);

  always @* begin
    sel_o = `SEL_NONE;
    if (use_pci_i) begin
      case (pci_offset_i) // [RQ15]
        `PCI_OFS_INJ_HIGH: sel_o = `SEL_INJ_HIGH;
        `PCI_OFS_INJ_LOW:  sel_o = `SEL_INJ_LOW;
        `PCI_OFS_INJ_PAR:  sel_o = `SEL_INJ_PAR;
        `PCI_OFS_CAP_HIGH: sel_o = `SEL_CAP_HIGH;
        `PCI_OFS_CAP_LOW:  sel_o = `SEL_CAP_LOW;
        `PCI_OFS_CAP_PAR:  sel_o = `SEL_CAP_PAR;
        default:           sel_o = `SEL_NONE;
      endcase
    end else begin
      case (lb_offset_i) // [RQ14]
        `LB_OFS_INJ_HIGH: sel_o = `SEL_INJ_HIGH;
        `LB_OFS_INJ_LOW:  sel_o = `SEL_INJ_LOW;
        `LB_OFS_INJ_PAR:  sel_o = `SEL_INJ_PAR;
        `LB_OFS_CAP_HIGH: sel_o = `SEL_CAP_HIGH;
        `LB_OFS_CAP_LOW:  sel_o = `SEL_CAP_LOW;
        `LB_OFS_CAP_PAR:  sel_o = `SEL_CAP_PAR;
        default:          sel_o = `SEL_NONE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [shared/mdp_diag_defs.vh]
// Constants for the memory data path error injection and capture block.
// Assumes inclusion by bare name from the design files.
`ifndef MDP_DIAG_DEFS_VH
`define MDP_DIAG_DEFS_VH

// Local bus window and register offsets within the utilities block.
`define LB_WIN_LO         20'hFF000
`define LB_WIN_HI         20'hFFFFF
`define LB_OFS_INJ_HIGH   20'hFF000
`define LB_OFS_INJ_LOW    20'hFF004
`define LB_OFS_INJ_PAR    20'hFF008
`define LB_OFS_CAP_HIGH   20'hFF00C
`define LB_OFS_CAP_LOW    20'hFF010
`define LB_OFS_CAP_PAR    20'hFF014

// PCI peripheral register window and offsets.
`define PCI_WIN_LO        12'hF00
`define PCI_WIN_HI        12'hFFF
`define PCI_OFS_INJ_HIGH  12'hF00
`define PCI_OFS_INJ_LOW   12'hF04
`define PCI_OFS_INJ_PAR   12'hF08
`define PCI_OFS_CAP_HIGH  12'hF0C
`define PCI_OFS_CAP_LOW   12'hF10
`define PCI_OFS_CAP_PAR   12'hF14

// Register selector codes, one-hot.
`define SEL_NONE          6'h00
`define SEL_INJ_HIGH      6'h01
`define SEL_INJ_LOW       6'h02
`define SEL_INJ_PAR       6'h04
`define SEL_CAP_HIGH      6'h08
`define SEL_CAP_LOW       6'h10
`define SEL_CAP_PAR       6'h20

// Field positions.
`define PAR_MSB           7
`define PAR_LSB           0
`define INJ_WR_EN_BIT     8
`define INJ_RD_EN_BIT     9
`define CAP_FLAG_BIT      8

// Reset values.
`define RST_WORD          32'h0000_0000
`define RST_PAR           8'h00

`endif

// [sim/mdp_error_inject_capture_bench.sv]
// Self-checking bench: register access on both ports, injection modes and capture.
// Assumes the memory side model and the bound checker are compiled alongside.
`default_nettype none
module mdp_error_inject_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, reset_n_i = 0, lb_sel_i = 0, lb_wr_i = 0, pci_sel_i = 0, pci_wr_i = 0;
  logic [19:0] lb_offset_i = 20'h0;
  logic [11:0] pci_offset_i = 12'h0;
  logic [3:0]  lb_be_i = 4'h0, pci_be_i = 4'h0;
  logic [31:0] lb_wdata_i = 32'h0, pci_wdata_i = 32'h0;
  wire  [31:0] lb_rdata_o, pci_rdata_o, rhi, rlo, whi, wlo, rhi_o, rlo_o, whi_o, wlo_o;
  wire  [7:0]  rpar, wpar, rpar_o, wpar_o;
  wire  [2:0]  err;
  wire         lb_hit_o, pci_hit_o, cap;
  integer      seed = 32'hA24F50E4, fails = 0, checks = 0, cyc = 0;
  mdp_mem_model model (.clk_i(clk_i), .rhi_o(rhi), .rlo_o(rlo), .whi_o(whi), .wlo_o(wlo),
    .rpar_o(rpar), .wpar_o(wpar), .err_o(err));
  mdp_error_inject_capture dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .lb_sel_i(lb_sel_i),
    .lb_wr_i(lb_wr_i), .lb_offset_i(lb_offset_i), .lb_be_i(lb_be_i), .lb_wdata_i(lb_wdata_i),
    .lb_rdata_o(lb_rdata_o), .lb_hit_o(lb_hit_o), .pci_sel_i(pci_sel_i), .pci_wr_i(pci_wr_i),
    .pci_offset_i(pci_offset_i), .pci_be_i(pci_be_i), .pci_wdata_i(pci_wdata_i),
    .pci_rdata_o(pci_rdata_o), .pci_hit_o(pci_hit_o), .rd_upper_word_bits_i(rhi),
    .rd_lower_word_bits_i(rlo), .rd_parity_lane_bits_i(rpar), .rd_upper_word_bits_o(rhi_o),
    .rd_lower_word_bits_o(rlo_o), .rd_parity_lane_bits_o(rpar_o), .wr_upper_word_bits_i(whi),
    .wr_lower_word_bits_i(wlo), .wr_parity_lane_bits_i(wpar), .wr_upper_word_bits_o(whi_o),
    .wr_lower_word_bits_o(wlo_o), .wr_parity_lane_bits_o(wpar_o), .err_rd_threshold_i(err[0]),
    .err_multi_bit_i(err[1]), .err_wr_parity_i(err[2]), .capture_valid_o(cap));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic sync;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [71:0] e, input logic [71:0] a);
    checks = checks + 1;
    if (a !== e) begin
      fails = fails + 1;
      $display("mismatch at %0t expected %h got %h", $time, e, a);
    end
  endtask
  // One access held for one cycle; read data is combinational and sampled mid-cycle.
  task automatic acc(input bit p, input bit w, input int i, input logic [3:0] be,
                     input logic [31:0] d, output logic [31:0] q);
    sync;
    if (p) {pci_sel_i, pci_wr_i, pci_offset_i, pci_be_i, pci_wdata_i} = {1'b1, w, 12'(3840 + 4 * i), be, d};
    else {lb_sel_i, lb_wr_i, lb_offset_i, lb_be_i, lb_wdata_i} = {1'b1, w, 20'(1044480 + 4 * i), be, d};
    #1 q = p ? pci_rdata_o : lb_rdata_o;
    sync;
    {lb_sel_i, lb_wr_i, pci_sel_i, pci_wr_i} = 4'h0;
  endtask
  task automatic rchk(input bit p, input int i, input logic [31:0] e);
    logic [31:0] q;
    acc(p, 1'b0, i, 4'hF, 32'h0, q);
    chk(e, q);
  endtask
  task automatic wr(input bit p, input int i, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] q;
    acc(p, 1'b1, i, be, d, q);
  endtask
  initial begin
    logic [31:0] mh, ml;
    logic [9:0]  mp;
    logic [71:0] e;
    repeat (16) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rchk(i % 2, i, 32'h0);
    end
    $display("reset values done");
    mh = $random(seed);
    ml = $random(seed);
    wr(0, 0, 4'hF, mh);
    wr(1, 1, 4'hF, ml);
    rchk(1, 0, mh);
    rchk(0, 1, ml);
    for (int k = 0; k < 4; k++) begin
      mp = {2'(k), 8'($random(seed))};
      wr(k % 2, 2, 4'h3, {22'h3FFFFF, mp});
      rchk(0, 2, {22'h0, mp});
      sync;
      #1 chk({rhi, rlo, rpar} ^ (mp[9] ? {mh, ml, mp[7:0]} : 72'h0), {rhi_o, rlo_o, rpar_o});
      chk({whi, wlo, wpar} ^ (mp[8] ? {mh, ml, mp[7:0]} : 72'h0), {whi_o, wlo_o, wpar_o});
    end
    wr(1, 2, 4'h1, 32'h0FF);
    rchk(1, 2, 32'h3FF);
    mp = 10'h3FF;
    $display("injection done");
    for (int k = 0; k < 3; k++) begin
      wr(k % 2, 5, 4'h2, 32'h0);
      chk(1'b0, cap);
      model.raise(k);
      sync;
      #1 e = (k < 2 ? {rhi, rlo, rpar} : {whi, wlo, wpar}) ^ {mh, ml, mp[7:0]};
      rchk(0, 3, e[71:40]);
      rchk(1, 4, e[39:8]);
      rchk(0, 5, {23'h0, 1'b1, e[7:0]});
      model.raise((k + 1) % 3);
      wr(0, 3, 4'hF, $random(seed));
      wr(1, 4, 4'hF, $random(seed));
      wr(0, 5, 4'h3, 32'hFFFFFFFF);
      rchk(1, 3, e[71:40]);
      rchk(0, 4, e[39:8]);
      rchk(1, 5, {23'h0, 1'b1, e[7:0]});
    end
    $display("capture done");
    rchk(0, 8, 32'h0);
    sync;
    {lb_sel_i, lb_offset_i, pci_sel_i, pci_offset_i} = {1'b1, 20'hFEFFC, 1'b1, 12'hEFC};
    #1 chk(33'h0, {lb_hit_o, lb_rdata_o});
    chk(33'h0, {pci_hit_o, pci_rdata_o});
    sync;
    {lb_sel_i, pci_sel_i} = 2'h0;
    $display("decode done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [sim/mdp_error_inject_capture_sva.sv]
// Port relations of the diagnostic block: decode, reserved bits, pass-through, capture flag.
// Assumes binding to the design top, every checker input named as the port it watches.
`default_nettype none
module mdp_eic_sva (
  input wire logic        clk_i, reset_n_i, lb_sel_i, lb_wr_i, pci_sel_i, pci_wr_i,
  input wire logic        lb_hit_o, pci_hit_o, capture_valid_o,
  input wire logic        err_rd_threshold_i, err_multi_bit_i, err_wr_parity_i,
  input wire logic [19:0] lb_offset_i,
  input wire logic [11:0] pci_offset_i,
  input wire logic [3:0]  lb_be_i, pci_be_i,
  input wire logic [31:0] lb_wdata_i, pci_wdata_i, lb_rdata_o,
  input wire logic [31:0] rd_upper_word_bits_i, rd_lower_word_bits_i,
  input wire logic [31:0] rd_upper_word_bits_o, rd_lower_word_bits_o,
  input wire logic [31:0] wr_upper_word_bits_i, wr_lower_word_bits_i,
  input wire logic [31:0] wr_upper_word_bits_o, wr_lower_word_bits_o,
  input wire logic [7:0]  rd_parity_lane_bits_i, rd_parity_lane_bits_o,
  input wire logic [7:0]  wr_parity_lane_bits_i, wr_parity_lane_bits_o
);
  wire any_err = err_rd_threshold_i || err_multi_bit_i || err_wr_parity_i;
  wire rd_par = lb_sel_i && !lb_wr_i && lb_offset_i == 20'hFF008;
  wire rd_cap = lb_sel_i && !lb_wr_i && lb_offset_i == 20'hFF014;
  wire clr = (lb_sel_i && lb_wr_i && lb_offset_i == 20'hFF014 && lb_be_i[1] && !lb_wdata_i[8])
    || (pci_sel_i && pci_wr_i && pci_offset_i == 12'hF14 && pci_be_i[1] && !pci_wdata_i[8]);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_lb_hit; lb_hit_o == (lb_sel_i && lb_offset_i >= 20'hFF000); endproperty
  a_lb_hit: assert property (p_lb_hit) else $error("local hit wrong");
  property p_pci_hit; pci_hit_o == (pci_sel_i && pci_offset_i >= 12'hF00); endproperty
  a_pci_hit: assert property (p_pci_hit) else $error("pci hit wrong");
  property p_miss; !lb_hit_o |-> lb_rdata_o == 32'h0; endproperty
  a_miss: assert property (p_miss) else $error("data outside window");
  property p_cap_set; any_err && !capture_valid_o |=> capture_valid_o; endproperty
  a_cap_set: assert property (p_cap_set) else $error("flag not set");
  property p_cap_cause; $rose(capture_valid_o) |-> $past(any_err); endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("flag set without error");
  property p_cap_keep; capture_valid_o && !clr |=> capture_valid_o; endproperty
  a_cap_keep: assert property (p_cap_keep) else $error("flag lost");
  property p_rd_pass; rd_par && !lb_rdata_o[9] |-> rd_upper_word_bits_o == rd_upper_word_bits_i
    && rd_lower_word_bits_o == rd_lower_word_bits_i
    && rd_parity_lane_bits_o == rd_parity_lane_bits_i; endproperty
  a_rd_pass: assert property (p_rd_pass) else $error("read altered");
  property p_wr_pass; rd_par && !lb_rdata_o[8] |-> wr_upper_word_bits_o == wr_upper_word_bits_i
    && wr_lower_word_bits_o == wr_lower_word_bits_i
    && wr_parity_lane_bits_o == wr_parity_lane_bits_i; endproperty
  a_wr_pass: assert property (p_wr_pass) else $error("write altered");
  property p_resv; rd_par |-> lb_rdata_o[31:10] == 22'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_flag; rd_cap |-> lb_rdata_o[31:8] == {23'h0, capture_valid_o}; endproperty
  a_flag: assert property (p_flag) else $error("flag bit wrong");
endmodule
bind mdp_error_inject_capture mdp_eic_sva u_sva (.*);
`default_nettype wire

// [sim/mdp_mem_model.sv]
// Memory side model: fresh path words every cycle and one-cycle error pulses on request.
// Assumes the bench calls raise() between clock edges.
`default_nettype none
module mdp_mem_model (
  input  wire logic        clk_i,
  output var  logic [31:0] rhi_o = 32'h0, rlo_o = 32'h0, whi_o = 32'h0, wlo_o = 32'h0,
  output var  logic [7:0]  rpar_o = 8'h0, wpar_o = 8'h0,
  output var  logic [2:0]  err_o = 3'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  integer     seed = 32'hA24F50E4;
  logic [2:0] pend = 3'h0;
  task automatic raise(input int k);
    pend[k] = 1'b1;
  endtask
  // Words change every cycle, so a late capture shows up as a wrong value.
  always @(posedge clk_i) begin
    {rhi_o, rlo_o, whi_o, wlo_o} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    {rpar_o, wpar_o} <= 16'($random(seed));
    err_o <= pend;
    pend = 3'h0;
  end
endmodule
`default_nettype wire
